// [src/pllcfg_pkg.sv]
// shared constants, field layouts and carrier types for the lock-detect and pump registers
package pllcfg_pkg;

    // register addresses on the serial load path
    localparam logic [5:0]  ADDR_LOCK_DETECT = 6'h07;
    localparam logic [5:0]  ADDR_ANALOG_EN   = 6'h08;
    localparam logic [5:0]  ADDR_PUMP        = 6'h09;

    // values after reset
    localparam logic [23:0] RST_LOCK_DETECT  = 24'h200844;
    localparam logic [23:0] RST_ANALOG_EN    = 24'h01bfff;
    localparam logic [23:0] RST_PUMP         = 24'h547264;

    // lock detect register fields
    localparam int          LOCK_WINCNT_LSB  = 0;
    localparam int          LOCK_ENABLE_BIT  = 11;
    localparam int          LOCK_TRAIN_BIT   = 20;
    localparam int          LOCK_SLIP_BIT    = 21;

    // analog enable register fields
    localparam int          AE_PORT_EN_BIT   = 5;
    localparam int          AE_BIAS_BIT      = 10;
    localparam int          AE_HIREF_BIT     = 21;
    localparam int          AE_LEVEL_BIT     = 22;

    // pump register fields
    localparam int          PUMP_DN_LSB      = 0;
    localparam int          PUMP_UP_LSB      = 7;
    localparam int          PUMP_OFS_LSB     = 14;
    localparam int          PUMP_OFS_UP_BIT  = 21;
    localparam int          PUMP_OFS_DN_BIT  = 22;
    localparam int          PUMP_HIGAIN_BIT  = 23;

    // pump current scaling, in microamps
    localparam logic [15:0] GAIN_STEP_UA     = 16'h0014;
    localparam logic [15:0] OFS_STEP_UA      = 16'h0005;
    localparam logic [15:0] SLIP_BOOST_UA    = 16'h1770;
    localparam logic [15:0] HIGAIN_BOOST_UA  = 16'h0bb8;

    // slip threshold, percent of comparison period
    localparam logic [6:0]  SLIP_PCT         = 7'h46;

    // consecutive in-window counts needed per selector code
    localparam logic [16:0] LOCK_COUNTS [8] = '{
        17'h00005, 17'h00020, 17'h00060, 17'h00100,
        17'h00200, 17'h00800, 17'h02000, 17'h0ffff
    };

    // lock detector settings
    typedef struct packed {
        logic [2:0] win_sel;
        logic       enable;
        logic       train;
    } pllcfg_lock_cfg_t;

    // pump settings
    typedef struct packed {
        logic [6:0] dn_code;
        logic [6:0] up_code;
        logic [6:0] ofs_code;
        logic       ofs_up_en;
        logic       ofs_dn_en;
        logic       high_gain_pump_mode;
        logic       cycle_slip_guard;
    } pllcfg_pump_cfg_t;

    // pump currents in microamps
    typedef struct packed {
        logic [15:0] up_ua;
        logic [15:0] dn_ua;
        logic [15:0] ofs_up_ua;
        logic [15:0] ofs_dn_ua;
    } pllcfg_pump_out_t;

endpackage : pllcfg_pkg

// [src/pllcfg_lock_detector.sv]
// lock detector: consecutive in-window counter with retraining
`timescale 1ns/1ps
module pllcfg_lock_detector #(
    parameter int CNT_W = 17
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // settings
    input  wire pllcfg_pkg::pllcfg_lock_cfg_t cfg,
    // divided oscillator samples
    input  wire logic                         sample_valid,
    input  wire logic                         sample_in_window,
    // status
    output logic                              locked,
    output logic                              training
);

    logic [CNT_W-1:0] count_q, count_d;
    logic             locked_q, locked_d;
    logic             train_prev_q, train_prev_d;
    logic             training_q, training_d;
    logic [CNT_W-1:0] target;

    assign target   = CNT_W'(pllcfg_pkg::LOCK_COUNTS[cfg.win_sel]);
    assign locked   = locked_q;
    assign training = training_q;

    always_comb begin
        count_d      = count_q;
        locked_d     = locked_q;
        training_d   = 1'b0;
        train_prev_d = cfg.train;
        if (cfg.train && !train_prev_q) begin
            count_d    = '0;
            locked_d   = 1'b0;
            training_d = 1'b1;
        end else if (!cfg.enable) begin
            count_d  = '0;
            locked_d = 1'b0;
        end else if (sample_valid) begin
            if (!sample_in_window) begin
                count_d  = '0;
                locked_d = 1'b0;
            end else if (count_q + CNT_W'(1) >= target) begin
                count_d  = target;
                locked_d = 1'b1;
            end else begin
                count_d = count_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q      <= '0;
            locked_q     <= 1'b0;
            train_prev_q <= 1'b0;
            training_q   <= 1'b0;
        end else begin
            count_q      <= count_d;
            locked_q     <= locked_d;
            train_prev_q <= train_prev_d;
            training_q   <= training_d;
        end
    end

endmodule : pllcfg_lock_detector

// [src/pllcfg_pump_ctrl.sv]
// charge pump current computation with cycle-slip boost
`timescale 1ns/1ps
module pllcfg_pump_ctrl (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // settings
    input  wire pllcfg_pkg::pllcfg_pump_cfg_t cfg,
    // phase detector status
    input  wire logic                         cycle_start,
    input  wire logic [6:0]                   phase_err_pct,
    // currents
    output pllcfg_pkg::pllcfg_pump_out_t      cur,
    output logic                              slip_boost
);

    pllcfg_pkg::pllcfg_pump_out_t cur_q, cur_d;
    logic                         boost_q, boost_d;
    logic [15:0]                  extra;

    assign cur        = cur_q;
    assign slip_boost = boost_q;

    always_comb begin
        boost_d = boost_q;
        if (cycle_start) begin
            boost_d = 1'b0;
        end
        if (cfg.cycle_slip_guard && phase_err_pct > pllcfg_pkg::SLIP_PCT) begin
            boost_d = 1'b1;
        end
        if (!cfg.cycle_slip_guard) begin
            boost_d = 1'b0;
        end
        extra = 16'h0000;
        if (boost_q) begin
            extra = extra + pllcfg_pkg::SLIP_BOOST_UA;
        end
        if (cfg.high_gain_pump_mode) begin
            extra = extra + pllcfg_pkg::HIGAIN_BOOST_UA;
        end
        cur_d.dn_ua = 16'(16'(cfg.dn_code) * pllcfg_pkg::GAIN_STEP_UA) + extra;
        cur_d.up_ua = 16'(16'(cfg.up_code) * pllcfg_pkg::GAIN_STEP_UA) + extra;
        cur_d.ofs_up_ua = cfg.ofs_up_en ?
            16'(16'(cfg.ofs_code) * pllcfg_pkg::OFS_STEP_UA) : 16'h0000;
        cur_d.ofs_dn_ua = cfg.ofs_dn_en ?
            16'(16'(cfg.ofs_code) * pllcfg_pkg::OFS_STEP_UA) : 16'h0000;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_q   <= '0;
            boost_q <= 1'b0;
        end else begin
            cur_q   <= cur_d;
            boost_q <= boost_d;
        end
    end

endmodule : pllcfg_pump_ctrl

// [src/pllcfg_regs.sv]
// lock detect, analog enable and charge pump configuration registers with their consumers
`timescale 1ns/1ps
module pllcfg_regs (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    // serial load path
    input  wire logic        SERIAL_LOAD_STROBE,
    input  wire logic [5:0]  SHIFT_ADDR,
    input  wire logic [23:0] SHIFT_WORD,
    input  wire logic [5:0]  READ_ADDR,
    output logic      [23:0] READ_DATA,
    // device context
    input  wire logic        OUT_PORT_MODE,
    input  wire logic [2:0]  CHIP_ADDR,
    input  wire logic        EXT_OSC_SEL,
    input  wire logic        GENERAL_OUTPUT_PORT,
    input  wire logic        SERIAL_OUT_DATA,
    // lock detector samples
    input  wire logic        DIV_SAMPLE_VALID,
    input  wire logic        DIV_SAMPLE_IN_WINDOW,
    // phase detector status
    input  wire logic        PFD_CYCLE_START,
    input  wire logic [6:0]  PHASE_ERR_PCT,
    // lock or serial output pin
    output logic             LOCK_OR_SERIAL_OUT_PIN_O,
    output logic             LOCK_OR_SERIAL_OUT_PIN_OE_B,
    output logic             PIN_LEVEL_3V,
    // status and analog settings
    output logic             LOCKED,
    output logic             TRAINING,
    output logic             SLIP_BOOST,
    output logic             HIGH_FREQ_REF,
    output logic             OSC_BIAS_EN,
    output logic      [15:0] PUMP_UP_UA,
    output logic      [15:0] PUMP_DN_UA,
    output logic      [15:0] PUMP_OFS_UP_UA,
    output logic      [15:0] PUMP_OFS_DN_UA
);

    // reset release through two flops
    logic                         rst_meta_q;
    logic                         rst_sync_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // register state
    logic [23:0]                  lock_detect_config_q, lock_detect_config_d;
    logic [23:0]                  analog_enable_config_q, analog_enable_config_d;
    logic [23:0]                  pump_current_config_q, pump_current_config_d;
    logic                         strobe_prev_q, strobe_prev_d;
    logic                         load_edge;

    assign load_edge = SERIAL_LOAD_STROBE && !strobe_prev_q;

    always_comb begin
        lock_detect_config_d   = lock_detect_config_q;
        analog_enable_config_d = analog_enable_config_q;
        pump_current_config_d  = pump_current_config_q;
        strobe_prev_d          = SERIAL_LOAD_STROBE;
        if (load_edge) begin
            if (SHIFT_ADDR == pllcfg_pkg::ADDR_LOCK_DETECT) begin
                lock_detect_config_d = SHIFT_WORD;
            end else if (SHIFT_ADDR == pllcfg_pkg::ADDR_ANALOG_EN) begin
                analog_enable_config_d = SHIFT_WORD;
            end else if (SHIFT_ADDR == pllcfg_pkg::ADDR_PUMP) begin
                pump_current_config_d = SHIFT_WORD;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            lock_detect_config_q   <= pllcfg_pkg::RST_LOCK_DETECT;
            analog_enable_config_q <= pllcfg_pkg::RST_ANALOG_EN;
            pump_current_config_q  <= pllcfg_pkg::RST_PUMP;
            strobe_prev_q          <= 1'b0;
        end else begin
            lock_detect_config_q   <= lock_detect_config_d;
            analog_enable_config_q <= analog_enable_config_d;
            pump_current_config_q  <= pump_current_config_d;
            strobe_prev_q          <= strobe_prev_d;
        end
    end

    // field extraction
    pllcfg_pkg::pllcfg_lock_cfg_t lock_cfg;
    pllcfg_pkg::pllcfg_pump_cfg_t pump_cfg;
    pllcfg_pkg::pllcfg_pump_out_t pump_cur;
    logic                         det_locked;
    logic                         det_training;
    logic                         pump_boost;

    assign lock_cfg.win_sel  = lock_detect_config_q[pllcfg_pkg::LOCK_WINCNT_LSB +: 3];
    assign lock_cfg.enable   = lock_detect_config_q[pllcfg_pkg::LOCK_ENABLE_BIT];
    assign lock_cfg.train    = lock_detect_config_q[pllcfg_pkg::LOCK_TRAIN_BIT];

    assign pump_cfg.dn_code             = pump_current_config_q[pllcfg_pkg::PUMP_DN_LSB +: 7];
    assign pump_cfg.up_code             = pump_current_config_q[pllcfg_pkg::PUMP_UP_LSB +: 7];
    assign pump_cfg.ofs_code            = pump_current_config_q[pllcfg_pkg::PUMP_OFS_LSB +: 7];
    assign pump_cfg.ofs_up_en           = pump_current_config_q[pllcfg_pkg::PUMP_OFS_UP_BIT];
    assign pump_cfg.ofs_dn_en           = pump_current_config_q[pllcfg_pkg::PUMP_OFS_DN_BIT];
    assign pump_cfg.high_gain_pump_mode = pump_current_config_q[pllcfg_pkg::PUMP_HIGAIN_BIT];
    assign pump_cfg.cycle_slip_guard    = lock_detect_config_q[pllcfg_pkg::LOCK_SLIP_BIT];

    pllcfg_lock_detector #(
        .CNT_W            (17)
    ) u_lock_detector (
        .clk              (CLK),
        .rst_b            (rst_sync_q),
        .cfg              (lock_cfg),
        .sample_valid     (DIV_SAMPLE_VALID),
        .sample_in_window (DIV_SAMPLE_IN_WINDOW),
        .locked           (det_locked),
        .training         (det_training)
    );

    pllcfg_pump_ctrl u_pump_ctrl (
        .clk           (CLK),
        .rst_b         (rst_sync_q),
        .cfg           (pump_cfg),
        .cycle_start   (PFD_CYCLE_START),
        .phase_err_pct (PHASE_ERR_PCT),
        .cur           (pump_cur),
        .slip_boost    (pump_boost)
    );

    // output stage: pin control, readback and settings
    logic                         pin_o_q, pin_o_d;
    logic                         pin_oe_b_q, pin_oe_b_d;
    logic                         level_q, level_d;
    logic [23:0]                  read_q, read_d;
    logic                         hiref_q, hiref_d;
    logic                         bias_q, bias_d;
    logic                         port_en;

    assign port_en = analog_enable_config_q[pllcfg_pkg::AE_PORT_EN_BIT];

    always_comb begin
        pin_o_d    = 1'b0;
        pin_oe_b_d = 1'b1;
        if (port_en && OUT_PORT_MODE) begin
            pin_oe_b_d = 1'b0;
            pin_o_d    = GENERAL_OUTPUT_PORT;
        end else if (port_en && CHIP_ADDR == 3'h0) begin
            // shared bus only at address zero
            pin_oe_b_d = 1'b0;
            pin_o_d    = SERIAL_OUT_DATA;
        end
        level_d = analog_enable_config_q[pllcfg_pkg::AE_LEVEL_BIT];
        // flag passed through as set by host
        hiref_d = analog_enable_config_q[pllcfg_pkg::AE_HIREF_BIT];
        bias_d  = analog_enable_config_q[pllcfg_pkg::AE_BIAS_BIT] && EXT_OSC_SEL;
        // unmapped addresses read as zero
        if (READ_ADDR == pllcfg_pkg::ADDR_LOCK_DETECT) begin
            read_d = lock_detect_config_q;
        end else if (READ_ADDR == pllcfg_pkg::ADDR_ANALOG_EN) begin
            read_d = analog_enable_config_q;
        end else if (READ_ADDR == pllcfg_pkg::ADDR_PUMP) begin
            read_d = pump_current_config_q;
        end else begin
            read_d = 24'h000000;
        end
    end

    always_ff @(posedge CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pin_o_q    <= 1'b0;
            pin_oe_b_q <= 1'b1;
            level_q    <= 1'b0;
            read_q     <= 24'h000000;
            hiref_q    <= 1'b0;
            bias_q     <= 1'b0;
        end else begin
            pin_o_q    <= pin_o_d;
            pin_oe_b_q <= pin_oe_b_d;
            level_q    <= level_d;
            read_q     <= read_d;
            hiref_q    <= hiref_d;
            bias_q     <= bias_d;
        end
    end

    assign LOCK_OR_SERIAL_OUT_PIN_O    = pin_o_q;
    assign LOCK_OR_SERIAL_OUT_PIN_OE_B = pin_oe_b_q;
    assign PIN_LEVEL_3V                = level_q;
    assign READ_DATA                   = read_q;
    assign HIGH_FREQ_REF               = hiref_q;
    assign OSC_BIAS_EN                 = bias_q;
    // submodule outputs are flops already
    assign LOCKED                      = det_locked;
    assign TRAINING                    = det_training;
    assign SLIP_BOOST                  = pump_boost;
    assign PUMP_UP_UA                  = pump_cur.up_ua;
    assign PUMP_DN_UA                  = pump_cur.dn_ua;
    assign PUMP_OFS_UP_UA              = pump_cur.ofs_up_ua;
    assign PUMP_OFS_DN_UA              = pump_cur.ofs_dn_ua;

endmodule : pllcfg_regs

// [sim/pllcfg_regs_asserts.sv]
// port-level checks for the lock detect and charge pump register block
`timescale 1ns/1ps
module pllcfg_regs_chk (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST_B,
    // load and readback
    input wire logic        SERIAL_LOAD_STROBE,
    input wire logic [5:0]  SHIFT_ADDR,
    input wire logic [23:0] SHIFT_WORD,
    input wire logic [5:0]  READ_ADDR,
    input wire logic [23:0] READ_DATA,
    // context
    input wire logic        OUT_PORT_MODE,
    input wire logic [2:0]  CHIP_ADDR,
    input wire logic        EXT_OSC_SEL,
    input wire logic        GENERAL_OUTPUT_PORT,
    input wire logic        SERIAL_OUT_DATA,
    input wire logic        DIV_SAMPLE_VALID,
    input wire logic        DIV_SAMPLE_IN_WINDOW,
    input wire logic        PFD_CYCLE_START,
    input wire logic [6:0]  PHASE_ERR_PCT,
    // outputs
    input wire logic        LOCK_OR_SERIAL_OUT_PIN_O,
    input wire logic        LOCK_OR_SERIAL_OUT_PIN_OE_B,
    input wire logic        PIN_LEVEL_3V,
    input wire logic        LOCKED,
    input wire logic        TRAINING,
    input wire logic        SLIP_BOOST,
    input wire logic        HIGH_FREQ_REF,
    input wire logic        OSC_BIAS_EN,
    input wire logic [15:0] PUMP_UP_UA,
    input wire logic [15:0] PUMP_DN_UA,
    input wire logic [15:0] PUMP_OFS_UP_UA,
    input wire logic [15:0] PUMP_OFS_DN_UA
);
    logic [23:0] lk_q, ae_q, pm_q, rd_exp;
    logic [16:0] run_q;
    logic [2:0]  up_q;
    logic        stb_q, rdy, load, trn, slip;
    logic [15:0] dn_exp, up_exp;
    // run count never below the design's, so a lock claim can be bounded from below
    assign load   = SERIAL_LOAD_STROBE && !stb_q;
    assign trn    = load && SHIFT_ADDR == 6'h07 && SHIFT_WORD[20] && !lk_q[20];
    assign rdy    = up_q == 3'h5;
    assign slip   = lk_q[21] && PHASE_ERR_PCT > 7'h46;
    assign dn_exp = 16'(pm_q[6:0]) * 16'h0014 + (pm_q[23] ? 16'h0bb8 : 16'h0)
                    + (SLIP_BOOST ? 16'h1770 : 16'h0);
    assign up_exp = 16'(pm_q[13:7]) * 16'h0014 + (pm_q[23] ? 16'h0bb8 : 16'h0)
                    + (SLIP_BOOST ? 16'h1770 : 16'h0);
    always_comb begin
        case (READ_ADDR)
            6'h07:   rd_exp = lk_q;
            6'h08:   rd_exp = ae_q;
            6'h09:   rd_exp = pm_q;
            default: rd_exp = 24'h0;
        endcase
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            {lk_q, ae_q, pm_q} <= {24'h200844, 24'h01bfff, 24'h547264};
            {up_q, stb_q, run_q} <= '0;
        end else begin
            stb_q <= SERIAL_LOAD_STROBE;
            up_q  <= rdy ? up_q : up_q + 3'h1;
            if (load && SHIFT_ADDR == 6'h07) lk_q <= SHIFT_WORD;
            if (load && SHIFT_ADDR == 6'h08) ae_q <= SHIFT_WORD;
            if (load && SHIFT_ADDR == 6'h09) pm_q <= SHIFT_WORD;
            if (DIV_SAMPLE_VALID && lk_q[11]) run_q <= DIV_SAMPLE_IN_WINDOW ? run_q + 17'h1 : '0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_pulse;
        TRAINING ##1 !TRAINING;
    endsequence
    chk_read_back: assert property (rdy |-> READ_DATA == $past(rd_exp))
        else $error("readback differs from loaded word");
    chk_pump_gain: assert property (rdy |-> PUMP_DN_UA == $past(dn_exp)
        && PUMP_UP_UA == $past(up_exp)) else $error("pump gain current wrong");
    chk_pump_offset: assert property (rdy |->
        PUMP_OFS_UP_UA == $past(pm_q[21] ? 16'(pm_q[20:14]) * 16'h0005 : 16'h0)
        && PUMP_OFS_DN_UA == $past(pm_q[22] ? 16'(pm_q[20:14]) * 16'h0005 : 16'h0))
        else $error("pump offset current wrong");
    chk_pin_enable: assert property (rdy |-> LOCK_OR_SERIAL_OUT_PIN_OE_B ==
        $past(!(ae_q[5] && (OUT_PORT_MODE || CHIP_ADDR == 3'h0)))) else $error("pin enable wrong");
    chk_pin_data: assert property (rdy && !LOCK_OR_SERIAL_OUT_PIN_OE_B |->
        LOCK_OR_SERIAL_OUT_PIN_O == $past(OUT_PORT_MODE ? GENERAL_OUTPUT_PORT : SERIAL_OUT_DATA))
        else $error("pin data wrong");
    chk_level_bits: assert property (rdy |-> PIN_LEVEL_3V == $past(ae_q[22])
        && HIGH_FREQ_REF == $past(ae_q[21]) && OSC_BIAS_EN == $past(ae_q[10] && EXT_OSC_SEL))
        else $error("analog setting output wrong");
    chk_slip_raise: assert property (rdy && slip |=> SLIP_BOOST)
        else $error("slip boost missing");
    chk_slip_hold: assert property (rdy && (PFD_CYCLE_START || !SLIP_BOOST) && !slip
        |=> !SLIP_BOOST) else $error("slip boost without cause");
    chk_train_pulse: assert property (rdy && trn |=> ##1 s_pulse)
        else $error("training pulse missing");
    chk_lock_count: assert property (rdy && $rose(LOCKED) |->
        run_q >= pllcfg_pkg::LOCK_COUNTS[lk_q[2:0]]) else $error("lock declared early");
    chk_lock_drop: assert property (rdy && DIV_SAMPLE_VALID && !DIV_SAMPLE_IN_WINDOW
        && lk_q[11] |=> ##[0:1] !LOCKED) else $error("lock kept after miss");
endmodule : pllcfg_regs_chk

bind pllcfg_regs pllcfg_regs_chk i_chk (.*);

// [sim/pllcfg_host_model.sv]
// host side of the serial load path: one word per strobe
`timescale 1ns/1ps
module pllcfg_host_model (
    // clock
    input  wire logic   clk,
    // load path
    output logic        strobe,
    output logic [5:0]  addr,
    output logic [23:0] word
);
    initial begin
        {strobe, addr, word} = '0;
    end
    task automatic load(input logic [5:0] a, input logic [23:0] w);
        @(posedge clk);
        strobe <= 1'b1;
        addr   <= a;
        word   <= w;
        @(posedge clk);
        strobe <= 1'b0;
        // released lines must not keep the last word
        addr   <= ~a;
        word   <= ~w;
    endtask : load
endmodule : pllcfg_host_model

// [sim/pllcfg_regs_test.sv]
// self-checking bench for the lock detect and charge pump registers
`timescale 1ns/1ps
module pllcfg_regs_test;
    logic        clk, rst_b, stb, opm, ext, gop, sod, vld, inw, cyc;
    logic        po, poe_b, lvl, lkd, trg, slp, hfr, bias;
    logic [5:0]  sa, ra;
    logic [23:0] sw, rd;
    logic [2:0]  chip;
    logic [6:0]  perr;
    logic [15:0] up, dn, oup, odn;
    logic [23:0] m [3] = '{24'h200844, 24'h01bfff, 24'h547264};
    int          cnt [8] = '{5, 32, 96, 256, 512, 2048, 8192, 65535};
    int          num_errors = 0;
    int          checks = 0;
    int          sb = 0;

    pllcfg_host_model i_host (.clk(clk), .strobe(stb), .addr(sa), .word(sw));
    pllcfg_regs i_dut (
        .CLK(clk), .RST_B(rst_b), .SERIAL_LOAD_STROBE(stb), .SHIFT_ADDR(sa),
        .SHIFT_WORD(sw), .READ_ADDR(ra), .READ_DATA(rd), .OUT_PORT_MODE(opm),
        .CHIP_ADDR(chip), .EXT_OSC_SEL(ext), .GENERAL_OUTPUT_PORT(gop),
        .SERIAL_OUT_DATA(sod), .DIV_SAMPLE_VALID(vld), .DIV_SAMPLE_IN_WINDOW(inw),
        .PFD_CYCLE_START(cyc), .PHASE_ERR_PCT(perr), .LOCK_OR_SERIAL_OUT_PIN_O(po),
        .LOCK_OR_SERIAL_OUT_PIN_OE_B(poe_b), .PIN_LEVEL_3V(lvl), .LOCKED(lkd),
        .TRAINING(trg), .SLIP_BOOST(slp), .HIGH_FREQ_REF(hfr), .OSC_BIAS_EN(bias),
        .PUMP_UP_UA(up), .PUMP_DN_UA(dn), .PUMP_OFS_UP_UA(oup), .PUMP_OFS_DN_UA(odn)
    );

    task automatic cmp_w(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_w
    task automatic cmp_b(input logic got, input logic exp);
        cmp_w({23'h0, got}, {23'h0, exp});
    endtask : cmp_b
    task automatic results;
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic wr(input logic [5:0] a, input logic [23:0] w);
        i_host.load(a, w);
        if (a >= 6'h07 && a <= 6'h09) m[a - 6'h07] = w;
    endtask : wr
    // reads all three registers plus an unmapped one, then every setting output
    task automatic chk_all;
        int d, u, o;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            ra <= 6'h07 + 6'(i);
            @(posedge clk);
            #1;
            cmp_w(rd, i < 3 ? m[i] : 24'h0);
        end
        d = m[2][6:0] * 20 + (m[2][23] ? 3000 : 0) + (sb != 0 ? 6000 : 0);
        u = m[2][13:7] * 20 + (m[2][23] ? 3000 : 0) + (sb != 0 ? 6000 : 0);
        o = m[2][20:14] * 5;
        cmp_w(24'(dn), 24'(d));
        cmp_w(24'(up), 24'(u));
        cmp_w(24'(odn), m[2][22] ? 24'(o) : 24'h0);
        cmp_w(24'(oup), m[2][21] ? 24'(o) : 24'h0);
        cmp_b(poe_b, !(m[1][5] && (opm || chip == 3'h0)));
        if (poe_b === 1'b0) cmp_b(po, opm ? gop : sod);
        cmp_b(lvl, m[1][22]);
        cmp_b(hfr, m[1][21]);
        cmp_b(bias, m[1][10] && ext);
        cmp_b(slp, sb != 0);
    endtask : chk_all
    task automatic lock_run(input int n);
        @(posedge clk);
        {vld, inw} <= 2'b11;
        repeat (n - 1) @(posedge clk);
        #1;
        cmp_b(lkd, 1'b0);
        @(posedge clk);
        #1;
        cmp_b(lkd, 1'b1);
        @(posedge clk);
        inw <= 1'b0;
        @(posedge clk);
        vld <= 1'b0;
        @(posedge clk);
        #1;
        cmp_b(lkd, 1'b0);
    endtask : lock_run

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // cut a hang short well after the longest lock run
    initial begin
        repeat (95000) @(posedge clk);
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        results();
    end
    initial begin
        {rst_b, opm, ext, gop, sod, vld, inw, cyc, chip, perr, ra} = '0;
        void'($urandom(96));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk_all();
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            {opm, ext, gop, sod} <= 4'($urandom);
            chip <= 3'(i);
            wr(6'h07 + 6'(i % 4), 24'($urandom));
            chk_all();
        end
        wr(6'h08, 24'h21bfff);
        wr(6'h09, 24'hffffff);
        chk_all();
        wr(6'h09, 24'h000000);
        chk_all();
        for (int c = 0; c < 8; c++) begin
            wr(6'h07, 24'h000800 | 24'(c));
            lock_run(cnt[c]);
        end
        wr(6'h07, 24'h000800);
        @(posedge clk);
        {vld, inw} <= 2'b11;
        repeat (6) @(posedge clk);
        // host retrains after a phase detector rate change
        wr(6'h07, 24'h100800);
        @(posedge clk);
        #1;
        cmp_b(trg, 1'b1);
        cmp_b(lkd, 1'b0);
        wr(6'h07, 24'h100800);
        @(posedge clk);
        #1;
        cmp_b(trg, 1'b0);
        @(posedge clk);
        inw <= 1'b0;
        wr(6'h07, 24'h000000);
        @(posedge clk);
        inw <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        cmp_b(lkd, 1'b0);
        @(posedge clk);
        {vld, inw} <= 2'b00;
        wr(6'h07, 24'h200800);
        @(posedge clk);
        perr <= 7'h46;
        repeat (3) @(posedge clk);
        #1;
        cmp_b(slp, 1'b0);
        @(posedge clk);
        perr <= 7'h47;
        @(posedge clk);
        perr <= 7'h00;
        sb = 1;
        chk_all();
        @(posedge clk);
        cyc <= 1'b1;
        @(posedge clk);
        cyc <= 1'b0;
        sb = 0;
        chk_all();
        wr(6'h07, 24'h000800);
        @(posedge clk);
        perr <= 7'h7f;
        chk_all();
        results();
    end
endmodule : pllcfg_regs_test
